// File: logic/tx_intake.sv
/*
 Transmit user intake: writes user cycles into a buffer, drives ready with
 grace headroom, and frames buffered data into bursts with control words.
 Assumes the application end keeps its own obligations; one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tx_intake #(
  parameter int DEPTH = ilk_tx_pkg::FIFO_DEPTH,
  parameter int BURST_MAX_B = ilk_tx_pkg::BURST_MAX_B,
  parameter int BURST_MIN_B = ilk_tx_pkg::BURST_MIN_B,
  parameter int BURST_SHORT_B = ilk_tx_pkg::BURST_SHORT_B
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic tx_hold, // Hold transmit path in reset
  input wire ilk_tx_pkg::tx_mode_e mode, // Packet or interleaved
  tx_user_if.dev usr, // Application side
  output logic lnk_valid, // Link word valid
  input wire logic lnk_ready, // Link accepts word
  output logic lnk_is_ctl, // Word is a burst control word
  output logic lnk_sob, // Control word opens a burst
  output logic lnk_eob, // Control word closes a burst
  output logic lnk_sop, // Burst or beat starts a packet
  output logic [ilk_tx_pkg::EOP_W-1:0] lnk_eop, // End field
  output logic [ilk_tx_pkg::CHAN_W-1:0] lnk_chan, // Channel
  output logic [ilk_tx_pkg::NV_W-1:0] lnk_nv, // Valid words
  output logic [ilk_tx_pkg::DATA_W-1:0] lnk_data, // Data beat
  output logic ovf // Sticky: write lost to full buffer
);
  localparam int BW = ilk_tx_pkg::BEAT_CNT_W;
  localparam int AFULL = DEPTH - ilk_tx_pkg::HEADROOM;
  localparam int MAX_BEATS = BURST_MAX_B / ilk_tx_pkg::BEAT_B;
  localparam int MIN_BEATS = BURST_MIN_B / ilk_tx_pkg::BEAT_B;
  localparam int SHORT_BEATS = BURST_SHORT_B / ilk_tx_pkg::BEAT_B;
  localparam int PKT_PAD =
    (MIN_BEATS > SHORT_BEATS) ? MIN_BEATS : SHORT_BEATS;
  localparam logic [BW-1:0] MAX_L = BW'(MAX_BEATS);
  localparam logic [BW-1:0] PKT_PAD_L = BW'(PKT_PAD);
  localparam logic [BW-1:0] ILV_PAD_L = BW'(SHORT_BEATS);

  if (AFULL < ilk_tx_pkg::GRACE_CYC || MAX_BEATS < 1 ||
      MAX_BEATS >= (1 << BW) || PKT_PAD >= (1 << BW) ||
      BURST_MIN_B > BURST_MAX_B) begin : g_chk
    $error("tx_intake: unsupported depth or burst settings");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BURST = 4'b0010,
    ST_END = 4'b0100,
    ST_GAP = 4'b1000
  } st_e;

  st_e st_q;
  st_e st_d;
  logic ready_q;
  logic ovf_q;
  logic [ilk_tx_pkg::CHAN_W-1:0] chan_q;
  logic [BW-1:0] beats_q;
  logic [BW-1:0] gap_q;
  logic [ilk_tx_pkg::EOP_W-1:0] eop_hold_q;
  logic fifo_wr_rdy;
  logic fifo_afull;
  logic rd_valid;
  logic rd_pop;
  ilk_tx_pkg::entry_s wr_ent;
  ilk_tx_pkg::entry_s hd;

  // Intake side
  wire ilv = (mode == ilk_tx_pkg::MODE_INTERLEAVED);
  wire wr_take = (usr.num_valid != ilk_tx_pkg::NV_IDLE) && !tx_hold;
  wire chan_cap = usr.sop || (ilv && usr.sob);
  wire [ilk_tx_pkg::CHAN_W-1:0] chan_in = chan_cap ? usr.chan : chan_q;

  assign wr_ent.data = usr.din_words;
  assign wr_ent.nv = usr.num_valid;
  assign wr_ent.sop = usr.sop;
  assign wr_ent.sob = ilv && usr.sob;
  assign wr_ent.eob = ilv && usr.eob;
  assign wr_ent.eop = usr.eopbits;
  assign wr_ent.chan = chan_in;
  assign usr.ready = ready_q;

  sync_fifo #(
    .W($bits(ilk_tx_pkg::entry_s)),
    .DEPTH(DEPTH),
    .AFULL_LVL(AFULL)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(tx_hold),
    .wr_valid(wr_take),
    .wr_ready(fifo_wr_rdy),
    .wr_data(wr_ent),
    .rd_valid(rd_valid),
    .rd_ready(rd_pop),
    .rd_data(hd),
    .afull(fifo_afull)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      chan_q <= ilk_tx_pkg::CHAN_RST;
      ovf_q <= 1'b0;
    end else begin
      ready_q <= !fifo_afull && !tx_hold;
      if (wr_take && chan_cap) chan_q <= usr.chan;
      if (wr_take && !fifo_wr_rdy) ovf_q <= 1'b1;
    end
  end

  // Drain side: burst framing
  wire adv = !lnk_valid || lnk_ready;
  wire eop_end = hd.eop[ilk_tx_pkg::EOP_FLAG_BIT];
  wire start_ok = !ilv || hd.sob;
  wire in_idle = (st_q == ST_IDLE);
  wire in_burst = (st_q == ST_BURST);
  wire emit_start = in_idle && rd_valid && start_ok;
  wire emit_data = rd_valid && (in_burst || (in_idle && !start_ok));
  wire emit_end = (st_q == ST_END);
  assign rd_pop = adv && emit_data;
  wire [BW-1:0] beats_nx = beats_q + 1'b1;
  // Interleaved bursts end on the application's flag, even mid-packet
  wire last_beat = ilv ? hd.eob : (eop_end || beats_nx >= MAX_L);
  wire [BW-1:0] pad_l = ilv ? ILV_PAD_L : PKT_PAD_L;
  wire need_gap = beats_q < pad_l;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (adv && emit_start) st_d = ST_BURST;
      ST_BURST: if (rd_pop && last_beat) st_d = ST_END;
      ST_END: if (adv) st_d = need_gap ? ST_GAP : ST_IDLE;
      ST_GAP: if (adv && gap_q <= 1) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      beats_q <= '0;
      gap_q <= '0;
      eop_hold_q <= ilk_tx_pkg::EOP_NONE;
    end else begin
      st_q <= tx_hold ? ST_IDLE : st_d;
      if (adv && emit_start) beats_q <= '0;
      else if (rd_pop && in_burst) beats_q <= beats_nx;
      if (rd_pop && in_burst && last_beat) eop_hold_q <= hd.eop;
      if (adv && emit_end) gap_q <= pad_l - beats_q;
      else if (adv && st_q == ST_GAP) gap_q <= gap_q - 1'b1;
    end
  end

  // Link output register, reloaded whenever the slot is free and tx_hold is low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lnk_valid <= 1'b0;
      lnk_is_ctl <= 1'b0;
      lnk_sob <= 1'b0;
      lnk_eob <= 1'b0;
      lnk_sop <= 1'b0;
      lnk_eop <= ilk_tx_pkg::EOP_NONE;
      lnk_chan <= ilk_tx_pkg::CHAN_RST;
      lnk_nv <= ilk_tx_pkg::NV_IDLE;
      lnk_data <= '0;
    end else if (tx_hold) begin
      lnk_valid <= 1'b0;
    end else if (adv) begin
      lnk_valid <= emit_start || emit_data || emit_end;
      lnk_is_ctl <= emit_start || emit_end;
      lnk_sob <= emit_start;
      lnk_eob <= emit_end;
      lnk_sop <= (emit_start || emit_data) && hd.sop;
      lnk_eop <= emit_end ? eop_hold_q
               : (emit_data ? hd.eop : ilk_tx_pkg::EOP_NONE);
      lnk_chan <= hd.chan;
      lnk_nv <= emit_data ? hd.nv : ilk_tx_pkg::NV_IDLE;
      lnk_data <= hd.data;
    end
  end

  assign ovf = ovf_q;
endmodule // tx_intake
`default_nettype wire

// File: common/ilk_tx_pkg.sv
/*
 Constants and types shared by the transmit user intake, its application
 end, the interface between them and the intake buffer.
 Assumes a single user clock for both ends.
*/
`default_nettype none
package ilk_tx_pkg;
  localparam int WORDS = 8;
  localparam int WORD_W = 64;
  localparam int DATA_W = WORDS * WORD_W;
  localparam int BEAT_B = 64;
  localparam int NV_W = 4;
  localparam int EOP_W = 4;
  localparam int CHAN_W = 8;
  localparam int EOP_FLAG_BIT = 3;
  localparam logic [3:0] NV_FULL = 4'h8;
  localparam logic [3:0] NV_IDLE = 4'h0;
  localparam logic [3:0] EOP_NONE = 4'h0;
  localparam logic [7:0] CHAN_RST = 8'h00;
  // Grace after ready falls: four cycles stated, up to eight tolerated
  localparam int GRACE_CYC = 4;
  localparam int GRACE_MAX_CYC = 8;
  // Ready is registered once in the intake and once in the application
  localparam int READY_LAT = 2;
  localparam int HEADROOM = GRACE_MAX_CYC + READY_LAT;
  localparam int FIFO_DEPTH = 32;
  localparam int BURST_MAX_B = 256;
  localparam int BURST_MIN_B = 128;
  localparam int BURST_SHORT_B = 64;
  localparam int ILV_BURST_LIM_B = 1024;
  localparam int BEAT_CNT_W = 8;

  typedef enum logic {
    MODE_PACKET = 1'b0,
    MODE_INTERLEAVED = 1'b1
  } tx_mode_e;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [NV_W-1:0] nv;
    logic sop;
    logic sob;
    logic eob;
    logic [EOP_W-1:0] eop;
    logic [CHAN_W-1:0] chan;
  } entry_s;
endpackage
`default_nettype wire

// File: common/tx_user_if.sv
/*
 Single-segment transmit user interface between application and intake.
 Assumes both ends run on the same clock; only segment bit 1 is carried.
*/
`timescale 1ns/100ps
`default_nettype none
interface tx_user_if;
  logic [ilk_tx_pkg::DATA_W-1:0] din_words;
  logic [ilk_tx_pkg::NV_W-1:0] num_valid;
  logic sop;
  logic sob;
  logic eob;
  logic [ilk_tx_pkg::EOP_W-1:0] eopbits;
  logic [ilk_tx_pkg::CHAN_W-1:0] chan;
  logic ready;

  modport dev (
    input din_words, num_valid, sop, sob, eob, eopbits, chan,
    output ready
  );
  modport app (
    output din_words, num_valid, sop, sob, eob, eopbits, chan,
    input ready
  );
endinterface
`default_nettype wire

// File: logic/sync_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides and an almost-full level.
 Assumes one clock; DEPTH a power of two.
*/
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32,
  parameter int AFULL_LVL = 22
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clr, // Synchronous flush
  input wire logic wr_valid, // Write request
  output logic wr_ready, // Space available
  input wire logic [W-1:0] wr_data, // Write word
  output logic rd_valid, // Word available
  input wire logic rd_ready, // Read accept
  output logic [W-1:0] rd_data, // Head word
  output logic afull // Level at or above AFULL_LVL
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || AFULL_LVL < 1 ||
      AFULL_LVL > DEPTH) begin : g_chk
    $error("sync_fifo: unsupported DEPTH or AFULL_LVL");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  wire [AW:0] level = wr_ptr_q - rd_ptr_q;
  wire full = level[AW];
  wire push = wr_valid && !full;
  wire pop = rd_ready && (level != '0);

  assign wr_ready = !full;
  assign rd_valid = (level != '0);
  assign rd_data = mem[rd_ptr_q[AW-1:0]];
  assign afull = level >= (AW+1)'(AFULL_LVL);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (clr) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule // sync_fifo
`default_nettype wire

// File: logic/tx_app.sv
/*
 Application end of the transmit user interface: registers user beats and
 ready, keeps idle cycles at zero count and watches interleaved burst size.
 Assumes the intake tolerates the grace cycles this registering costs.
*/
`timescale 1ns/100ps
`default_nettype none
module tx_app (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic usr_valid, // User beat offered
  output logic usr_ready, // Beat taken this cycle
  input wire logic [ilk_tx_pkg::DATA_W-1:0] usr_data, // MSB-packed words
  input wire logic [ilk_tx_pkg::NV_W-1:0] usr_nv, // Valid words
  input wire logic usr_sop, // Packet start
  input wire logic usr_sob, // Burst start
  input wire logic usr_eob, // Burst end
  input wire logic [ilk_tx_pkg::EOP_W-1:0] usr_eop, // End field
  input wire logic [ilk_tx_pkg::CHAN_W-1:0] usr_chan, // Channel
  tx_user_if.app lnk, // Intake side
  output logic long_burst // Sticky: burst above size limit
);
  localparam int LIM_BEATS = ilk_tx_pkg::ILV_BURST_LIM_B /
                             ilk_tx_pkg::BEAT_B;
  localparam int BW = ilk_tx_pkg::BEAT_CNT_W;
  localparam logic [BW-1:0] LIM_L = BW'(LIM_BEATS);

  logic ready_q;
  logic [ilk_tx_pkg::DATA_W-1:0] data_q;
  logic [ilk_tx_pkg::NV_W-1:0] nv_q;
  logic sop_q;
  logic sob_q;
  logic eob_q;
  logic [ilk_tx_pkg::EOP_W-1:0] eop_q;
  logic [ilk_tx_pkg::CHAN_W-1:0] chan_q;
  logic [BW-1:0] bcnt_q;
  logic long_q;

  wire take = usr_valid && ready_q && (usr_nv != ilk_tx_pkg::NV_IDLE);
  wire [BW-1:0] bcnt_nx = (usr_sob ? '0 : bcnt_q) + 1'b1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      data_q <= '0;
      nv_q <= ilk_tx_pkg::NV_IDLE;
      sop_q <= 1'b0;
      sob_q <= 1'b0;
      eob_q <= 1'b0;
      eop_q <= ilk_tx_pkg::EOP_NONE;
      chan_q <= ilk_tx_pkg::CHAN_RST;
      bcnt_q <= '0;
      long_q <= 1'b0;
    end else begin
      ready_q <= lnk.ready;
      data_q <= usr_data;
      nv_q <= take ? usr_nv : ilk_tx_pkg::NV_IDLE;
      sop_q <= take && usr_sop;
      sob_q <= take && usr_sob;
      eob_q <= take && usr_eob;
      eop_q <= take ? usr_eop : ilk_tx_pkg::EOP_NONE;
      if (take && (usr_sop || usr_sob)) chan_q <= usr_chan;
      if (take) bcnt_q <= bcnt_nx;
      if (take && bcnt_nx > LIM_L) long_q <= 1'b1;
    end
  end

  assign usr_ready = ready_q;
  assign lnk.din_words = data_q;
  assign lnk.num_valid = nv_q;
  assign lnk.sop = sop_q;
  assign lnk.sob = sob_q;
  assign lnk.eob = eob_q;
  assign lnk.eopbits = eop_q;
  assign lnk.chan = chan_q;
  assign long_burst = long_q;
endmodule // tx_app
`default_nettype wire

// File: sim/intake_monitor.sv
/*
 Checker on the user interface joining the application end and the intake.
 Assumes one clock and one reset; it sees only the interface signals.
*/
`timescale 1ns/100ps
`default_nettype none
module intake_monitor (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [ilk_tx_pkg::DATA_W-1:0] din_words, // Data words
  input wire logic [ilk_tx_pkg::NV_W-1:0] num_valid, // Valid words
  input wire logic sop, // Packet start
  input wire logic sob, // Burst start
  input wire logic eob, // Burst end
  input wire logic [ilk_tx_pkg::EOP_W-1:0] eopbits, // End field
  input wire logic [ilk_tx_pkg::CHAN_W-1:0] chan, // Channel
  input wire logic ready // Intake ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [ilk_tx_pkg::CHAN_W-1:0] chan_q;
  logic [ilk_tx_pkg::CHAN_W-1:0] chan_d;
  wire beat = num_valid != ilk_tx_pkg::NV_IDLE;
  wire start = beat && (sop || sob);
  // Words beyond the valid count
  wire [ilk_tx_pkg::DATA_W-1:0] low_mask =
    {ilk_tx_pkg::DATA_W{1'b1}} >> (num_valid * ilk_tx_pkg::WORD_W);
  assign chan_d = start ? chan : chan_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) chan_q <= ilk_tx_pkg::CHAN_RST;
    else chan_q <= chan_d;
  end
  sequence s_boot;
    $rose(rst_n);
  endsequence
  sequence s_up;
    !ready ##1 ready;
  endsequence
  sequence s_held;
    !ready [*3];
  endsequence
  nv_range_a: assert property (num_valid <= ilk_tx_pkg::NV_FULL)
    else $error("word count above eight");
  partial_end_a: assert property (beat && num_valid != ilk_tx_pkg::NV_FULL
    |-> eopbits[ilk_tx_pkg::EOP_FLAG_BIT])
    else $error("partial cycle without packet end");
  grace_stop_a: assert property (s_held |-> !beat)
    else $error("write long after ready fell");
  boot_ready_a: assert property (s_boot |-> s_up)
    else $error("ready not raised after reset");
  boot_idle_a: assert property (s_boot |-> !beat [*2])
    else $error("write right after reset");
  chan_held_a: assert property (beat && !sop && !sob |-> chan == chan_q)
    else $error("channel changed inside burst");
  eop_field_a: assert property (beat && !eopbits[3] |-> eopbits[2:0] == 3'h0)
    else $error("byte count without packet end");
  msb_pack_a: assert property (beat |-> (din_words & low_mask) == '0)
    else $error("data outside valid words");
endmodule // intake_monitor
`default_nettype wire

// File: sim/interlaken_tx_user_intake_bench.sv
/*
 Bench for the application end joined to the intake by the user interface.
 Assumes one 40 MHz clock; drives the user side and the link stall.
*/
`timescale 1ns/100ps
`default_nettype none
module interlaken_tx_user_intake_bench;
  localparam int DLY = 2;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic tx_hold = 1'b0;
  logic lnk_ready = 1'b1;
  ilk_tx_pkg::tx_mode_e mode = ilk_tx_pkg::MODE_PACKET;
  logic usr_valid = 1'b0, usr_sop = 1'b0, usr_sob = 1'b0, usr_eob = 1'b0;
  logic [ilk_tx_pkg::DATA_W-1:0] usr_data = '0;
  logic [3:0] usr_nv = 4'h0, usr_eop = 4'h0;
  logic [7:0] usr_chan = 8'h00;
  logic usr_ready, long_burst, ovf, lnk_valid, lnk_is_ctl;
  logic lnk_sob, lnk_eob, lnk_sop;
  logic [3:0] lnk_eop, lnk_nv;
  logic [7:0] lnk_chan;
  logic [ilk_tx_pkg::DATA_W-1:0] lnk_data;
  int err_total = 0, comparisons = 0, cyc = 0, wr_cnt = 0;
  logic [27:0] q[$];
  tx_user_if ifc();
  wire open_w = lnk_is_ctl && lnk_sob;
  always #12.5 clk_sys = ~clk_sys;
  tx_app tx_app_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .usr_valid(usr_valid), .usr_ready(usr_ready), .usr_data(usr_data),
    .usr_nv(usr_nv), .usr_sop(usr_sop), .usr_sob(usr_sob),
    .usr_eob(usr_eob), .usr_eop(usr_eop), .usr_chan(usr_chan),
    .lnk(ifc), .long_burst(long_burst));
  tx_intake tx_intake_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .tx_hold(tx_hold), .mode(mode), .usr(ifc), .lnk_valid(lnk_valid),
    .lnk_ready(lnk_ready), .lnk_is_ctl(lnk_is_ctl), .lnk_sob(lnk_sob),
    .lnk_eob(lnk_eob), .lnk_sop(lnk_sop), .lnk_eop(lnk_eop),
    .lnk_chan(lnk_chan), .lnk_nv(lnk_nv), .lnk_data(lnk_data), .ovf(ovf));
  intake_monitor intake_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .din_words(ifc.din_words), .num_valid(ifc.num_valid), .sop(ifc.sop),
    .sob(ifc.sob), .eob(ifc.eob), .eopbits(ifc.eopbits), .chan(ifc.chan),
    .ready(ifc.ready));
  // Link word summary: flags, end field, channel, count, top data byte
  always @(posedge clk_sys) begin
    if (rst_n && lnk_valid === 1'b1 && lnk_ready)
      q.push_back({lnk_is_ctl, lnk_sob, lnk_eob, lnk_sop,
        open_w ? 4'h0 : lnk_eop, open_w ? lnk_chan : 8'h00, lnk_nv,
        lnk_is_ctl ? 8'h00 : lnk_data[511:504]});
    if (rst_n && !tx_hold && ifc.num_valid !== 4'h0) wr_cnt++;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [27:0] w(input logic [3:0] f, e,
    input logic [7:0] c, input logic [3:0] n, input logic [7:0] t);
    return {f, e, c, n, t};
  endfunction
  task automatic want(input logic [27:0] e);
    while (q.size() == 0) @(posedge clk_sys) #DLY;
    chk("link word", q.pop_front(), e);
  endtask
  task automatic send(input logic [7:0] t, input logic [3:0] n,
    input logic [2:0] f, input logic [3:0] e, input logic [7:0] c);
    usr_valid = 1'b1;
    usr_data = {t, {(ilk_tx_pkg::DATA_W-8){1'b0}}};
    {usr_sop, usr_sob, usr_eob} = f;
    usr_nv = n;
    usr_eop = e;
    usr_chan = c;
    while (usr_ready !== 1'b1) @(posedge clk_sys) #DLY;
    @(posedge clk_sys) #DLY;
  endtask
  task automatic quiet();
    usr_valid = 1'b0;
    @(posedge clk_sys) #DLY;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #DLY rst_n = 1'b1;
  endtask
  task automatic test_packet();
    mode = ilk_tx_pkg::MODE_PACKET;
    send(8'h11, 4'h8, 3'b111, 4'h0, 8'h02);
    send(8'h22, 4'h8, 3'b011, 4'h0, 8'h02);
    send(8'h33, 4'h7, 3'b011, 4'hB, 8'h02);
    quiet();
    want(w(4'hD, 4'h0, 8'h02, 4'h0, 8'h00));
    want(w(4'h1, 4'h0, 8'h00, 4'h8, 8'h11));
    want(w(4'h0, 4'h0, 8'h00, 4'h8, 8'h22));
    want(w(4'h0, 4'hB, 8'h00, 4'h7, 8'h33));
    want(w(4'hA, 4'hB, 8'h00, 4'h0, 8'h00));
    // Five-beat packet: burst cut after the maximum beat count
    send(8'h61, 4'h8, 3'b110, 4'h0, 8'h03);
    send(8'h62, 4'h8, 3'b000, 4'h0, 8'h03);
    send(8'h63, 4'h8, 3'b000, 4'h0, 8'h03);
    send(8'h64, 4'h8, 3'b000, 4'h0, 8'h03);
    send(8'h65, 4'h4, 3'b000, 4'h8, 8'h03);
    quiet();
    want(w(4'hD, 4'h0, 8'h03, 4'h0, 8'h00));
    want(w(4'h1, 4'h0, 8'h00, 4'h8, 8'h61));
    want(w(4'h0, 4'h0, 8'h00, 4'h8, 8'h62));
    want(w(4'h0, 4'h0, 8'h00, 4'h8, 8'h63));
    want(w(4'h0, 4'h0, 8'h00, 4'h8, 8'h64));
    want(w(4'hA, 4'h0, 8'h00, 4'h0, 8'h00));
    want(w(4'hC, 4'h0, 8'h03, 4'h0, 8'h00));
    want(w(4'h0, 4'h8, 8'h00, 4'h4, 8'h65));
    want(w(4'hA, 4'h8, 8'h00, 4'h0, 8'h00));
    $display("test_packet done");
  endtask
  task automatic test_interleaved();
    mode = ilk_tx_pkg::MODE_INTERLEAVED;
    send(8'h01, 4'h8, 3'b110, 4'h0, 8'h02);
    send(8'h02, 4'h8, 3'b001, 4'h0, 8'h02);
    send(8'h03, 4'h3, 3'b111, 4'hB, 8'h04);
    quiet();
    send(8'h05, 4'h8, 3'b011, 4'h0, 8'h02);
    send(8'h07, 4'h8, 3'b110, 4'h0, 8'h05);
    send(8'h08, 4'h2, 3'b001, 4'hB, 8'h05);
    quiet();
    want(w(4'hD, 4'h0, 8'h02, 4'h0, 8'h00));
    want(w(4'h1, 4'h0, 8'h00, 4'h8, 8'h01));
    want(w(4'h0, 4'h0, 8'h00, 4'h8, 8'h02));
    want(w(4'hA, 4'h0, 8'h00, 4'h0, 8'h00));
    want(w(4'hD, 4'h0, 8'h04, 4'h0, 8'h00));
    want(w(4'h1, 4'hB, 8'h00, 4'h3, 8'h03));
    want(w(4'hA, 4'hB, 8'h00, 4'h0, 8'h00));
    want(w(4'hC, 4'h0, 8'h02, 4'h0, 8'h00));
    want(w(4'h0, 4'h0, 8'h00, 4'h8, 8'h05));
    want(w(4'hA, 4'h0, 8'h00, 4'h0, 8'h00));
    want(w(4'hD, 4'h0, 8'h05, 4'h0, 8'h00));
    want(w(4'h1, 4'h0, 8'h00, 4'h8, 8'h07));
    want(w(4'h0, 4'hB, 8'h00, 4'h2, 8'h08));
    want(w(4'hA, 4'hB, 8'h00, 4'h0, 8'h00));
    chk("long burst", long_burst, 1'b0);
    $display("test_interleaved done");
  endtask
  task automatic test_backpressure();
    int base, n, ctl;
    base = wr_cnt;
    n = 0;
    ctl = 0;
    lnk_ready = 1'b0;
    send(8'h40, 4'h8, 3'b110, 4'h0, 8'h07);
    while (usr_ready === 1'b1 && n < 40) begin
      send(8'h41, 4'h8, 3'b000, 4'h0, 8'h07);
      n++;
    end
    chk("ready", ifc.ready, 1'b0);
    quiet();
    repeat (12) @(posedge clk_sys) #DLY;
    chk("overflow", ovf, 1'b0);
    lnk_ready = 1'b1;
    send(8'h42, 4'h8, 3'b001, 4'h8, 8'h07);
    quiet();
    while (q.size() < n + 4) @(posedge clk_sys) #DLY;
    foreach (q[i]) ctl += q[i][27];
    chk("writes", wr_cnt - base, n + 2);
    chk("data words", q.size() - ctl, n + 2);
    chk("ctl words", ctl, 2);
    chk("long burst", long_burst, 1'b1);
    q.delete();
    $display("test_backpressure done");
  endtask
  task automatic test_hold();
    tx_hold = 1'b1;
    usr_valid = 1'b1;
    repeat (3) @(posedge clk_sys) #DLY;
    chk("hold ready", ifc.ready, 1'b0);
    chk("hold words", q.size(), 0);
    tx_hold = 1'b0;
    send(8'h50, 4'h1, 3'b111, 4'h8, 8'h09);
    quiet();
    // Beats offered under hold must not reach the link
    want(w(4'hD, 4'h0, 8'h09, 4'h0, 8'h00));
    want(w(4'h1, 4'h8, 8'h00, 4'h1, 8'h50));
    want(w(4'hA, 4'h8, 8'h00, 4'h0, 8'h00));
    do_reset();
    chk("long cleared", long_burst, 1'b0);
    chk("ovf cleared", ovf, 1'b0);
    send(8'h60, 4'h8, 3'b111, 4'h8, 8'h0A);
    quiet();
    want(w(4'hD, 4'h0, 8'h0A, 4'h0, 8'h00));
    want(w(4'h1, 4'h8, 8'h00, 4'h8, 8'h60));
    want(w(4'hA, 4'h8, 8'h00, 4'h0, 8'h00));
    $display("test_hold done");
  endtask
  initial begin
    do_reset();
    test_packet();
    test_interleaved();
    test_backpressure();
    test_hold();
    summarize();
  end
endmodule // interlaken_tx_user_intake_bench
`default_nettype wire
